//--- verilog/alcc_top.sv
`timescale 1ns/100ps
`default_nettype none
module alcc_top
    import alcc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Power modes
    input  wire logic        stop3_mode,
    input  wire logic        deep_stop,
    // Triggers and clock sources
    input  wire logic        hw_trigger,
    input  wire logic        alt_tick,
    input  wire logic        async_tick,
    // Analog front end
    input  wire logic [9:0]  conv_sample,
    output logic [4:0]       analog_channel,
    output logic             low_power,
    output logic [15:0]      pin_digital_off,
    // Status
    output logic             conv_active,
    output logic             conv_irq
);
    alcc_regs_t r;
    alcc_regs_t nx;
    logic       adck_tick;
    logic       div_run;
    logic       setup;
    logic       wr;
    logic       rd;
    logic       is10;
    logic [9:0] value;
    logic [9:0] cv_eff;
    logic [9:0] diff;
    logic       cmp_ok;
    logic       blocked;
    logic       finish;
    logic       conv_complete_flag_set;
    logic       conv_complete_flag_clr;
    logic       async_sel;
    logic       stop3_abort;
    logic       hw_start;
    logic       sc1_start;

    function automatic logic addr_known(input logic [7:0] a);
        return a == OFS_CFG || a == OFS_SC2 || a == OFS_SC1 || a == OFS_RES_HI
            || a == OFS_RES_LO || a == OFS_CV_HI || a == OFS_CV_LO || a == OFS_PIN1
            || a == OFS_PIN2;
    endfunction

    function automatic logic [5:0] conv_len(input logic long_smp, input logic ten);
        logic [5:0] s;
        logic [5:0] b;
        s = long_smp ? SAMPLE_LONG_TICKS : SAMPLE_SHORT_TICKS;
        b = ten ? BITS_10_TICKS : BITS_8_TICKS;
        return s + b + EXTRA_TICKS;
    endfunction

    function automatic logic [31:0] read_word(input logic [7:0] a, input alcc_regs_t q, input logic ten);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            OFS_CFG:    v = q.cfg;
            OFS_SC2: begin
                v[SC2_ACT_BIT]   = q.act; // [RULE14]
                v[SC2_TRG_BIT]   = q.trg;
                v[SC2_CMPEN_BIT] = q.cmpen;
                v[SC2_CMPGT_BIT] = q.cmpgt; // Bits 3:0 stay zero [RULE16]
            end
            OFS_SC1: begin
                v[SC1_CONV_COMPLETE_FLAG_BIT] = q.conv_complete_flag; // [RULE17]
                v[SC1_IEN_BIT]  = q.ien;
                v[SC1_CONT_BIT] = q.cont;
                v[SC1_CHAN_LSB +: 5] = q.chan;
            end
            OFS_RES_HI: v = ten ? {6'h00, q.res[9:8]} : 8'h00;
            OFS_RES_LO: v = q.res[7:0];
            OFS_CV_HI:  v = {6'h00, q.cv[9:8]};
            OFS_CV_LO:  v = q.cv[7:0];
            OFS_PIN1:   v = q.pin1;
            OFS_PIN2:   v = q.pin2;
            default:    v = 8'h00;
        endcase
        return {24'h000000, v};
    endfunction

    assign async_sel = r.cfg[CFG_CLK_LSB +: 2] == CLK_ASYNC;
    // The bus clock stops in stop3, so only the async source keeps ticking [RULE4]
    assign div_run   = (r.state == ST_CONV) && !deep_stop && (!stop3_mode || async_sel);

    alcc_clk_div u_div (
        .pclk       (pclk),
        .presetn    (presetn),
        .run        (div_run),
        .clk_src    (r.cfg[CFG_CLK_LSB +: 2]),
        .div_sel    (r.cfg[CFG_DIV_LSB +: 2]),
        .alt_tick   (alt_tick),
        .async_tick (async_tick),
        .adck_tick  (adck_tick)
    );

    always_comb begin
        nx          = r;
        setup       = psel && !penable;
        wr          = psel && penable && r.pready && pwrite;
        rd          = psel && penable && r.pready && !pwrite;
        is10        = r.cfg[CFG_MODE_LSB +: 2] == MODE_10BIT; // [RULE12]
        value       = is10 ? conv_sample : {2'h0, conv_sample[9:2]};
        cv_eff      = is10 ? r.cv : {2'h0, r.cv[7:0]};
        diff        = value - cv_eff;
        cmp_ok      = !r.cmpen || (r.cmpgt ? (value >= cv_eff) : (value < cv_eff)); // [RULE25]
        blocked     = is10 && r.lock; // [RULE23]
        finish      = (r.state == ST_CONV) && adck_tick && (r.cnt == CNT_LAST);
        conv_complete_flag_set    = finish && !blocked && cmp_ok; // [RULE7] [RULE17]
        conv_complete_flag_clr    = (wr && paddr == OFS_SC1) || (rd && paddr == OFS_RES_LO);
        stop3_abort = stop3_mode && !r.stop3_q && !async_sel; // [RULE1]
        hw_start    = hw_trigger && r.trg && (r.chan != CHAN_OFF) && (r.state == ST_IDLE)
                      && (!stop3_mode || async_sel); // [RULE6] [RULE15]
        sc1_start   = wr && (paddr == OFS_SC1) && (pwdata[SC1_CHAN_LSB +: 5] != CHAN_OFF);

        // Bus answer: zero wait states, data registered in the setup cycle
        nx.pready  = setup;
        nx.pslverr = setup && !addr_known(paddr);
        if (setup) begin
            nx.prdata = read_word(paddr, r, is10);
        end

        // Conversion progress
        if ((r.state == ST_CONV) && adck_tick) begin
            nx.cnt = r.cnt - 6'h01;
        end
        if (finish) begin
            if (conv_complete_flag_set) begin
                nx.res = r.cmpen ? diff : value;
            end
            // A blocked result refires unless single compare-miss; otherwise continuous refires
            if ((blocked && !(r.cmpen && !cmp_ok && !r.cont)) || (!blocked && r.cont)) begin // [RULE18] [RULE5]
                nx.cnt = conv_len(r.cfg[CFG_LONG_BIT], is10);
            end else begin
                nx.state = ST_IDLE;
            end
        end
        if (hw_start) begin
            nx.state = ST_CONV;
            nx.cnt   = conv_len(r.cfg[CFG_LONG_BIT], is10);
        end

        // In 10-bit mode, reading the high byte holds off new results until the low byte is read
        if (rd && paddr == OFS_RES_HI && is10) begin
            nx.lock = 1'b1;
        end
        if (rd && paddr == OFS_RES_LO) begin
            nx.lock = 1'b0;
        end

        if (wr) begin
            case (paddr)
                OFS_CFG: begin
                    nx.cfg   = pwdata[7:0]; // [RULE10] [RULE13]
                    nx.state = ST_IDLE;
                end
                OFS_SC2: begin
                    nx.trg   = pwdata[SC2_TRG_BIT];
                    nx.cmpen = pwdata[SC2_CMPEN_BIT];
                    nx.cmpgt = pwdata[SC2_CMPGT_BIT];
                    nx.state = ST_IDLE;
                end
                OFS_SC1: begin
                    nx.ien   = pwdata[SC1_IEN_BIT];
                    nx.cont  = pwdata[SC1_CONT_BIT];
                    nx.chan  = pwdata[SC1_CHAN_LSB +: 5]; // [RULE19]
                    nx.state = sc1_start ? ST_CONV : ST_IDLE; // [RULE24]
                    nx.cnt   = conv_len(r.cfg[CFG_LONG_BIT], is10);
                end
                OFS_CV_HI: begin
                    nx.cv[9:8] = pwdata[1:0];
                    nx.state   = ST_IDLE;
                end
                OFS_CV_LO: begin
                    nx.cv[7:0] = pwdata[7:0];
                    nx.state   = ST_IDLE;
                end
                OFS_PIN1: nx.pin1 = pwdata[7:0]; // [RULE22]
                OFS_PIN2: nx.pin2 = pwdata[7:0];
                default: nx.pin1 = r.pin1;
            endcase
        end

        // Set wins over clear
        nx.conv_complete_flag = (r.conv_complete_flag && !conv_complete_flag_clr) || conv_complete_flag_set;
        if (stop3_abort) begin
            nx.state = ST_IDLE; // [RULE1] [RULE3]
        end
        nx.stop3_q = stop3_mode;
        nx.irq     = r.conv_complete_flag && r.ien; // [RULE7]
        nx.act     = nx.state == ST_CONV; // [RULE14]

        // Deepest stop: everything but the bus answer and the stop3 sample back to reset
        if (deep_stop) begin
            nx         = REGS_RST; // [RULE9]
            nx.pready  = setup;
            nx.pslverr = setup && !addr_known(paddr);
            nx.prdata  = r.prdata;
            nx.stop3_q = stop3_mode;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= REGS_RST;
        end else begin
            r <= nx;
        end
    end

    assign prdata          = r.prdata;
    assign pready          = r.pready;
    assign pslverr         = r.pslverr;
    assign analog_channel  = r.chan;
    assign low_power       = r.cfg[CFG_LOWPWR_BIT]; // [RULE10]
    assign pin_digital_off = {r.pin2, r.pin1}; // [RULE22]
    assign conv_active     = r.act;
    assign conv_irq        = r.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_stop3_entry_sync;
        stop3_mode && !r.stop3_q && !async_sel && !deep_stop;
    endsequence

    sequence s_quiet_idle;
        (r.state == ST_IDLE) && !hw_start && !(wr && paddr == OFS_SC1);
    endsequence

    chk_stop3_abort: assert property (s_stop3_entry_sync |=> r.state == ST_IDLE && !conv_active) // [RULE1]
        else $error("stop3 entry did not abort conversion");
    chk_result_hold: assert property (!conv_complete_flag_set && !deep_stop |=> $stable(r.res)) // [RULE2]
        else $error("result changed without a completed conversion");
    chk_stay_idle: assert property (s_quiet_idle ##0 !deep_stop |=> r.state == ST_IDLE) // [RULE3]
        else $error("converter left idle without a trigger");
    chk_async_runs: assert property ((r.state == ST_CONV) && stop3_mode && async_sel && !finish
                                     && !wr && !deep_stop |=> r.state == ST_CONV) // [RULE4]
        else $error("async conversion stopped in stop3");
    chk_done_flag: assert property (conv_complete_flag_set && !deep_stop |=> r.conv_complete_flag ##1 (conv_irq == $past(r.ien))) // [RULE7]
        else $error("completion did not set flag and interrupt");
    chk_deep_reset: assert property (deep_stop |=> r.cfg == CFG_RST && r.chan == CHAN_OFF
                                     && !r.conv_complete_flag && r.state == ST_IDLE) // [RULE9]
        else $error("deep stop did not restore reset values");
    chk_sc2_zero: assert property (setup && paddr == OFS_SC2 |=> prdata[3:0] == 4'h0) // [RULE16]
        else $error("reserved status bits read nonzero");
    chk_block_drop: assert property (finish && blocked && !deep_stop |=> $stable(r.res)
                                     && (r.conv_complete_flag == $past(r.conv_complete_flag && !conv_complete_flag_clr))) // [RULE23]
        else $error("blocked result was transferred");
    chk_sc1_abort: assert property (wr && paddr == OFS_SC1 && !deep_stop
                                    |=> (r.state == ST_CONV) == ($past(sc1_start) && !$past(stop3_abort))) // [RULE24]
        else $error("status one write did not abort or restart");
    chk_cmp_miss: assert property (finish && r.cmpen && !cmp_ok && !deep_stop |=> $stable(r.res)) // [RULE25]
        else $error("compare miss transferred a result");
    chk_active_rd: assert property (setup && paddr == OFS_SC2 |=> prdata[SC2_ACT_BIT] == $past(r.act)) // [RULE14]
        else $error("active flag read wrong");
endmodule // alcc_top
`default_nettype wire

//--- verilog/alcc_pkg.sv
// What this block does
// RULE1: Entering stop3 without the async clock selected aborts the conversion and idles.
// RULE2: Stop3 entry or exit leaves both result bytes unchanged.
// RULE3: After a stop3 abort, stay idle until a software or hardware trigger.
// RULE4: With the async clock selected, the converter keeps running in stop3.
// RULE5: A conversion underway at stop3 entry completes when the async clock is selected.
// RULE6: In stop3 with async clock, hardware trigger or continuous mode start conversions.
// RULE7: Completion in stop3 sets the complete flag and raises the interrupt if enabled.
// RULE8: Software clears a pending result-read block before entering stop3.
// RULE9: Stop1 or stop2 disables the module and returns every register to reset. The code keeps the bus answer and the stop3 sample.
// RULE10: Configuration bit 7 selects low power, bit 4 selects long sample time.
// RULE11: Configuration bits 6:5 divide the input clock; 00 divides by one.
// RULE12: Configuration bits 3:2 choose resolution; 10 selects 10-bit.
// RULE13: Configuration bits 1:0 choose the input clock; 00 is the bus clock.
// RULE14: Status/control two bit 7 reads high while a conversion is in progress.
// RULE15: Status/control two bit 6 selects hardware trigger, bit 5 enables compare.
// RULE16: Status/control two bits 3:2 read zero; software writes zero to bits 1:0.
// RULE17: Status/control one bit 7 is a read-only flag set when a conversion finishes.
// RULE18: Status/control one bit 6 enables the interrupt, bit 5 selects continuous mode.
// RULE19: Status/control one bits 4:0 pick the channel; 00001 is channel one.
// RULE20: Software reads the high result byte before the low byte.
// RULE21: Software writes configuration, then status/control two, then status/control one.
// RULE22: A set pin control bit disables digital I/O on that analog input.
// RULE23: In 10-bit mode a result arriving between high and low byte reads is discarded.
// RULE24: Any status/control one write aborts; it starts anew unless the channel is all ones.
// RULE25: With compare on, the flag sets only when the result meets the compare limit.
`default_nettype none
package alcc_pkg;
    // Register byte addresses
    localparam logic [7:0] OFS_CFG    = 8'h00;
    localparam logic [7:0] OFS_SC2    = 8'h04;
    localparam logic [7:0] OFS_SC1    = 8'h08;
    localparam logic [7:0] OFS_RES_HI = 8'h0C;
    localparam logic [7:0] OFS_RES_LO = 8'h10;
    localparam logic [7:0] OFS_CV_HI  = 8'h14;
    localparam logic [7:0] OFS_CV_LO  = 8'h18;
    localparam logic [7:0] OFS_PIN1   = 8'h1C;
    localparam logic [7:0] OFS_PIN2   = 8'h20;
    // Configuration fields
    localparam int CFG_LOWPWR_BIT = 7;
    localparam int CFG_DIV_LSB    = 5;
    localparam int CFG_LONG_BIT   = 4;
    localparam int CFG_MODE_LSB   = 2;
    localparam int CFG_CLK_LSB    = 0;
    // Status/control fields
    localparam int SC2_ACT_BIT    = 7;
    localparam int SC2_TRG_BIT    = 6;
    localparam int SC2_CMPEN_BIT  = 5;
    localparam int SC2_CMPGT_BIT  = 4;
    localparam int SC1_CONV_COMPLETE_FLAG_BIT   = 7;
    localparam int SC1_IEN_BIT    = 6;
    localparam int SC1_CONT_BIT   = 5;
    localparam int SC1_CHAN_LSB   = 0;
    // Codes
    localparam logic [1:0] MODE_10BIT   = 2'h2;
    localparam logic [1:0] CLK_BUS      = 2'h0;
    localparam logic [1:0] CLK_BUS_HALF = 2'h1;
    localparam logic [1:0] CLK_ALT      = 2'h2;
    localparam logic [1:0] CLK_ASYNC    = 2'h3;
    localparam logic [4:0] CHAN_OFF     = 5'h1F;
    // Reset values
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] PIN_RST = 8'h00;
    localparam logic [9:0] CV_RST  = 10'h000;
    localparam logic [9:0] RES_RST = 10'h000;
    // Conversion timing in converter clock ticks
    localparam logic [5:0] SAMPLE_SHORT_TICKS = 6'h04;
    localparam logic [5:0] SAMPLE_LONG_TICKS  = 6'h18;
    localparam logic [5:0] BITS_8_TICKS       = 6'h08;
    localparam logic [5:0] BITS_10_TICKS      = 6'h0A;
    localparam logic [5:0] EXTRA_TICKS        = 6'h02;
    localparam logic [5:0] CNT_LAST           = 6'h01;

    typedef enum logic [0:0] {ST_IDLE, ST_CONV} alcc_conv_state_t;

    typedef struct packed {
        alcc_conv_state_t state;
        logic [5:0]       cnt;
        logic [7:0]       cfg;
        logic             trg;
        logic             cmpen;
        logic             cmpgt;
        logic             ien;
        logic             cont;
        logic [4:0]       chan;
        logic             conv_complete_flag;
        logic             act;
        logic             lock;
        logic [9:0]       res;
        logic [9:0]       cv;
        logic [7:0]       pin1;
        logic [7:0]       pin2;
        logic             stop3_q;
        logic             irq;
        logic             pready;
        logic             pslverr;
        logic [31:0]      prdata;
    } alcc_regs_t;

    localparam alcc_regs_t REGS_RST = '{
        state: ST_IDLE, cnt: 6'h00, cfg: CFG_RST, trg: 1'b0, cmpen: 1'b0, cmpgt: 1'b0,
        ien: 1'b0, cont: 1'b0, chan: CHAN_OFF, conv_complete_flag: 1'b0, act: 1'b0, lock: 1'b0,
        res: RES_RST, cv: CV_RST, pin1: PIN_RST, pin2: PIN_RST, stop3_q: 1'b0,
        irq: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};

    typedef struct packed {
        logic       half;
        logic [2:0] cnt;
        logic       tick;
    } alcc_div_t;
endpackage
`default_nettype wire

//--- verilog/alcc_clk_div.sv
`timescale 1ns/100ps
`default_nettype none
module alcc_clk_div
    import alcc_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control
    input  wire logic       run,
    input  wire logic [1:0] clk_src,
    input  wire logic [1:0] div_sel,
    input  wire logic       alt_tick,
    input  wire logic       async_tick,
    // Converter clock enable
    output logic            adck_tick
);
    alcc_div_t r;
    alcc_div_t nx;
    logic      src_tick;
    logic [2:0] mask;

    always_comb begin
        nx = r;
        case (clk_src)
            CLK_BUS:      src_tick = 1'b1;
            CLK_BUS_HALF: src_tick = r.half;
            CLK_ALT:      src_tick = alt_tick;
            CLK_ASYNC:    src_tick = async_tick;
            default:      src_tick = 1'b0;
        endcase
        case (div_sel) // [RULE11]
            2'h0:    mask = 3'h0;
            2'h1:    mask = 3'h1;
            2'h2:    mask = 3'h3;
            default: mask = 3'h7;
        endcase
        nx.tick = 1'b0;
        if (!run) begin
            nx.half = 1'b0;
            nx.cnt  = 3'h0;
        end else begin
            nx.half = !r.half;
            if (src_tick) begin
                if (r.cnt == mask) begin
                    nx.cnt  = 3'h0;
                    nx.tick = 1'b1;
                end else begin
                    nx.cnt = r.cnt + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{half: 1'b0, cnt: 3'h0, tick: 1'b0};
        end else begin
            r <= nx;
        end
    end

    assign adck_tick = r.tick;
endmodule // alcc_clk_div
`default_nettype wire

//--- testbench/alcc_tick_src.sv
`timescale 1ns/100ps
`default_nettype none
module alcc_tick_src (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Clock enable pulses
    output logic      async_tick,
    output logic      alt_tick
);
    logic [1:0] async_cnt;
    logic [2:0] alt_cnt;

    // Async source is free running, also through stop3
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            async_cnt <= 2'h0;
            alt_cnt   <= 3'h0;
        end else begin
            async_cnt <= (async_cnt == 2'h2) ? 2'h0 : async_cnt + 2'h1;
            alt_cnt   <= (alt_cnt == 3'h4) ? 3'h0 : alt_cnt + 3'h1;
        end
    end

    assign async_tick = (async_cnt == 2'h2);
    assign alt_tick   = (alt_cnt == 3'h4);
endmodule // alcc_tick_src
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
    import alcc_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        stop3_mode, deep_stop, hw_trigger, alt_tick, async_tick;
    logic        low_power, conv_active, conv_irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  conv_sample;
    logic [4:0]  analog_channel;
    logic [15:0] pin_digital_off;
    int          mismatches, checks_done, n1, n2;

    alcc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stop3_mode(stop3_mode), .deep_stop(deep_stop), .hw_trigger(hw_trigger), .alt_tick(alt_tick),
        .async_tick(async_tick), .conv_sample(conv_sample), .analog_channel(analog_channel),
        .low_power(low_power), .pin_digital_off(pin_digital_off), .conv_active(conv_active),
        .conv_irq(conv_irq));

    alcc_tick_src src_u (.pclk(pclk), .presetn(presetn), .async_tick(async_tick), .alt_tick(alt_tick));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; commits at the edge with pready high, then lets one idle edge pass
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        check(32'(pready), 32'h1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // Ends at a falling edge a few cycles after the converter went idle
    task automatic wait_idle(output int n);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (conv_active !== 1'b0 && n < 400);
        check(32'(conv_active), 32'h0);
        repeat (3) @(negedge pclk);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #(8 * 20000);
        mismatches++;
        tally_and_finish;
    end

    initial begin
        {presetn, psel, penable, pwrite, stop3_mode, deep_stop, hw_trigger} = 7'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        conv_sample = 10'h2A5;
        mismatches = 0;
        checks_done = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(OFS_CFG, 32'h00);
        rd_chk(OFS_SC2, 32'h00);
        rd_chk(OFS_SC1, 32'h1F);
        apb(1'b0, 8'h24, 32'h0);
        check({rd[31:1], err}, 32'h1);
        // Configuration, then control two, then control one
        apb(1'b1, OFS_CFG, 32'h98);
        apb(1'b1, OFS_SC2, 32'h00);
        apb(1'b1, OFS_PIN1, 32'h02);
        apb(1'b1, OFS_SC1, 32'h41);
        @(negedge pclk);
        check(32'(analog_channel), 32'h01);
        check(32'(pin_digital_off), 32'h0002);
        check(32'(low_power), 32'h1);
        @(posedge pclk);
        rd_chk(OFS_SC2, 32'h80);
        rd_chk(OFS_CFG, 32'h98);
        wait_idle(n1);
        check(32'(conv_irq), 32'h1);
        @(posedge pclk);
        rd_chk(OFS_SC1, 32'hC1);
        rd_chk(OFS_RES_HI, 32'h02);
        rd_chk(OFS_RES_LO, 32'hA5);
        apb(1'b1, OFS_SC1, 32'h9F);
        rd_chk(OFS_SC1, 32'h1F);
        apb(1'b1, OFS_SC2, 32'h0C);
        rd_chk(OFS_SC2, 32'h00);
        // Divide by one, then by two
        apb(1'b1, OFS_CFG, 32'h08);
        apb(1'b1, OFS_SC1, 32'h01);
        wait_idle(n1);
        @(posedge pclk);
        apb(1'b1, OFS_CFG, 32'h28);
        apb(1'b1, OFS_SC1, 32'h01);
        wait_idle(n2);
        check(32'(n1 >= 14 && n1 <= 20), 32'h1);
        check(32'(n2 >= 2 * n1 - 3 && n2 <= 2 * n1 + 3), 32'h1);
        @(posedge pclk);
        // Stop3 on the bus clock aborts
        apb(1'b1, OFS_CFG, 32'h08);
        conv_sample <= 10'h155;
        apb(1'b1, OFS_SC1, 32'h01);
        repeat (4) @(posedge pclk);
        stop3_mode <= 1'b1;
        repeat (3) @(negedge pclk);
        check(32'(conv_active), 32'h0);
        @(posedge pclk);
        stop3_mode <= 1'b0;
        repeat (60) @(posedge pclk);
        check(32'(conv_active), 32'h0);
        rd_chk(OFS_SC1, 32'h01);
        rd_chk(OFS_RES_HI, 32'h02);
        rd_chk(OFS_RES_LO, 32'hA5);
        // Async clock keeps converting through stop3
        apb(1'b1, OFS_CFG, 32'h0B);
        apb(1'b1, OFS_SC2, 32'h40);
        apb(1'b1, OFS_SC1, 32'h41);
        stop3_mode <= 1'b1;
        wait_idle(n1);
        check(32'(n1 > 20), 32'h1);
        check(32'(conv_irq), 32'h1);
        @(posedge pclk);
        rd_chk(OFS_RES_HI, 32'h01);
        rd_chk(OFS_RES_LO, 32'h55);
        conv_sample <= 10'h0F0;
        hw_trigger <= 1'b1;
        @(posedge pclk);
        hw_trigger <= 1'b0;
        wait_idle(n2);
        check(32'(n2 > 20), 32'h1);
        check(32'(conv_irq), 32'h1);
        @(posedge pclk);
        stop3_mode <= 1'b0;
        rd_chk(OFS_RES_HI, 32'h00);
        rd_chk(OFS_RES_LO, 32'hF0);
        // Result dropped while the high byte is read but not the low
        apb(1'b1, OFS_CFG, 32'h08);
        apb(1'b1, OFS_SC2, 32'h00);
        apb(1'b1, OFS_SC1, 32'h01);
        wait_idle(n1);
        @(posedge pclk);
        rd_chk(OFS_RES_HI, 32'h00);
        conv_sample <= 10'h3C3;
        apb(1'b1, OFS_SC1, 32'h01);
        repeat (40) @(negedge pclk);
        check(32'(conv_active), 32'h1);
        @(posedge pclk);
        rd_chk(OFS_SC1, 32'h01);
        rd_chk(OFS_RES_LO, 32'hF0);
        wait_idle(n1);
        @(posedge pclk);
        rd_chk(OFS_RES_HI, 32'h03);
        rd_chk(OFS_RES_LO, 32'hC3);
        // Compare against 0x100, greater-or-equal then less-than
        apb(1'b1, OFS_SC2, 32'h30);
        apb(1'b1, OFS_CV_HI, 32'h01);
        apb(1'b1, OFS_CV_LO, 32'h00);
        conv_sample <= 10'h0FF;
        apb(1'b1, OFS_SC1, 32'h01);
        wait_idle(n1);
        @(posedge pclk);
        rd_chk(OFS_SC1, 32'h01);
        conv_sample <= 10'h180;
        apb(1'b1, OFS_SC1, 32'h01);
        wait_idle(n1);
        @(posedge pclk);
        rd_chk(OFS_SC1, 32'h81);
        rd_chk(OFS_RES_HI, 32'h00);
        rd_chk(OFS_RES_LO, 32'h80);
        apb(1'b1, OFS_SC2, 32'h20);
        conv_sample <= 10'h0FF;
        apb(1'b1, OFS_SC1, 32'h01);
        wait_idle(n1);
        @(posedge pclk);
        rd_chk(OFS_RES_HI, 32'h03);
        rd_chk(OFS_RES_LO, 32'hFF);
        // Continuous mode, then a channel of all ones stops it
        apb(1'b1, OFS_SC2, 32'h00);
        apb(1'b1, OFS_SC1, 32'h21);
        repeat (60) @(posedge pclk);
        rd_chk(OFS_SC1, 32'hA1);
        apb(1'b1, OFS_SC1, 32'h1F);
        repeat (2) @(negedge pclk);
        check(32'(conv_active), 32'h0);
        // Eight-bit results from half bus clock divided by eight, then from the alternate source
        @(posedge pclk);
        apb(1'b1, OFS_CFG, 32'h61);
        apb(1'b1, OFS_SC1, 32'h01);
        wait_idle(n1);
        @(posedge pclk);
        apb(1'b1, OFS_CFG, 32'h02);
        apb(1'b1, OFS_SC1, 32'h01);
        wait_idle(n2);
        check(32'(n1 >= 215 && n1 <= 235), 32'h1);
        check(32'(n2 >= 60 && n2 <= 80), 32'h1);
        @(posedge pclk);
        rd_chk(OFS_RES_HI, 32'h00);
        rd_chk(OFS_RES_LO, 32'h3F);
        // Deep stop returns everything but the bus answer and the stop3 sample to reset
        @(posedge pclk);
        apb(1'b1, OFS_CFG, 32'h98);
        apb(1'b1, OFS_PIN1, 32'h02);
        deep_stop <= 1'b1;
        @(posedge pclk);
        deep_stop <= 1'b0;
        @(negedge pclk);
        check(32'(low_power), 32'h0);
        check(32'(pin_digital_off), 32'h0000);
        check(32'(analog_channel), 32'h1F);
        @(posedge pclk);
        rd_chk(OFS_CFG, 32'h00);
        rd_chk(OFS_RES_LO, 32'h00);
        apb(1'b1, OFS_CFG, 32'h98);
        rd_chk(OFS_CFG, 32'h98);
        tally_and_finish;
    end
endmodule // testbench
`default_nettype wire
